// *** mwx_crossbar.sv ***
`timescale 1ns/1ps
`include "mwx_map.svh"
// Operation
// - Decode module from address, then connect
// - Concurrent routes, one requester per module
// - Whole word carried in parallel both ways
// - 48 data bits plus parity stored
// - 4096 words per module, eight modules
// - Each module owns address, buffer registers
// - Cycle 6 or 4 us; busy till done
// - Read word usable at 3 or 2 us
// - Only processors and IO units request
// - Two processor and four IO ports
// - One common clock for everything
// - 15-bit address: 3 module, 12 word
// - New route per access, one word each
// - Connect only to an idle module
module mwx_crossbar
	import mwx_pkg::*;
#(
	parameter int NUM_REQ = `MWX_NUM_REQ,
	parameter int NUM_MOD = `MWX_NUM_MOD,
	parameter int DEPTH = `MWX_MOD_DEPTH,
	parameter bit FAST_MODULES = 1'b0
) (
	// Clock and reset
	input wire logic clock_i,
	input wire logic reset_i,
	// Requesters: 0-1 processors, 2-5 IO control units
	input wire logic [NUM_REQ-1:0] req_i,
	input wire logic [NUM_REQ-1:0] write_i,
	input wire mwx_pkg::mwx_addr_type addr_i [NUM_REQ],
	input wire mwx_pkg::mwx_word_type wdata_i [NUM_REQ],
	// Answers to requesters
	output logic [NUM_REQ-1:0] grant_o,
	output logic [NUM_REQ-1:0] rvalid_o,
	output logic [NUM_REQ-1:0] done_o,
	output mwx_pkg::mwx_word_type rdata_o [NUM_REQ]
);
	// Requester ports: two processors, four IO units
	// Timing choice: all modules one type, never mixed
	localparam int CYC_NS = FAST_MODULES ? `MWX_FAST_CYCLE_NS : `MWX_SLOW_CYCLE_NS;
	localparam int RD_NS = FAST_MODULES ? `MWX_FAST_READ_NS : `MWX_SLOW_READ_NS;
	// Longest-time style rounding down; figures divide evenly at 4 ns
	localparam int CYCLE_CLKS = CYC_NS / `MWX_CLK_NS;
	localparam int READ_CLKS = RD_NS / `MWX_CLK_NS;
	localparam int IDX_W = $clog2(NUM_REQ + 1);

	// Route owner per module; NUM_REQ means no route
	logic [IDX_W-1:0] owner [NUM_MOD];
	logic [IDX_W-1:0] next_owner [NUM_MOD];
	logic [NUM_REQ-1:0] active, next_active; // Requester has a route
	logic [NUM_MOD-1:0] start; // Start pulse per module
	logic [NUM_REQ-1:0] next_grant;
	logic [NUM_REQ-1:0] rvalid, next_rvalid;
	logic [NUM_REQ-1:0] done, next_done;
	mwx_word_type rdata [NUM_REQ];
	mwx_word_type next_rdata [NUM_REQ];

	mwx_port_if mport [NUM_MOD] ();

	// Busy, done and read pulses gathered from modules
	logic [NUM_MOD-1:0] mbusy, mdone, mrvalid;
	mwx_word_type mrdata [NUM_MOD];

	// Module target of each requester from the high address bits
	function automatic logic [`MWX_MSEL_W-1:0] msel(input mwx_addr_type a);
		msel = a[`MWX_ADDR_W-1:`MWX_MSEL_LSB];
	endfunction

	// Arbitration and route setup for every module
	always_comb begin
		next_active = active;
		next_grant = '0;
		start = '0;
		for (int m = 0; m < NUM_MOD; m++) begin
			next_owner[m] = owner[m];
		end
		for (int m = 0; m < NUM_MOD; m++) begin
			// Only an idle, unowned module takes a new route
			if (owner[m] == IDX_W'(NUM_REQ) && !mbusy[m]) begin
				// Lowest index wins: processors before IO units
				for (int r = NUM_REQ - 1; r >= 0; r--) begin
					if (req_i[r] && !active[r] && !done[r]
						&& msel(addr_i[r]) == m[`MWX_MSEL_W-1:0]) begin
						next_owner[m] = IDX_W'(r);
					end
				end
				if (next_owner[m] != IDX_W'(NUM_REQ)) begin
					start[m] = 1'b1;
					next_active[next_owner[m]] = 1'b1;
					next_grant[next_owner[m]] = 1'b1;
				end
			end else if (owner[m] != IDX_W'(NUM_REQ) && mdone[m]) begin
				next_owner[m] = IDX_W'(NUM_REQ);
				next_active[owner[m]] = 1'b0;
			end
		end
	end

	// One module per generate step, each with its own route
	generate
		for (genvar g = 0; g < NUM_MOD; g++) begin : g_mod
			logic [IDX_W-1:0] sel;
			assign sel = next_owner[g] == IDX_W'(NUM_REQ) ? '0 : next_owner[g];
			// Whole word and address cross in parallel
			assign mport[g].start = start[g];
			assign mport[g].write = write_i[sel];
			assign mport[g].waddr = addr_i[sel][`MWX_WADDR_W-1:0];
			assign mport[g].wdata = wdata_i[sel];
			assign mbusy[g] = mport[g].busy;
			assign mdone[g] = mport[g].done;
			assign mrvalid[g] = mport[g].rvalid;
			assign mrdata[g] = mport[g].rdata;
			// Independent module, own registers
			mwx_module #(
				.DEPTH(DEPTH),
				.CYCLE_CLKS(CYCLE_CLKS),
				.READ_CLKS(READ_CLKS)
			) u_mod (
				.clock_i(clock_i),
				.reset_i(reset_i),
				.port(mport[g])
			);
		end
	endgenerate

	// Return path: word and pulses back to the route owner
	always_comb begin
		next_rvalid = '0;
		next_done = '0;
		for (int r = 0; r < NUM_REQ; r++) begin
			next_rdata[r] = rdata[r];
		end
		for (int m = 0; m < NUM_MOD; m++) begin
			if (owner[m] != IDX_W'(NUM_REQ)) begin
				if (mrvalid[m]) begin
					next_rvalid[owner[m]] = 1'b1;
					next_rdata[owner[m]] = mrdata[m];
				end
				if (mdone[m]) begin
					next_done[owner[m]] = 1'b1;
				end
			end
		end
	end

	// Register routes and answers on the one system clock
	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			for (int m = 0; m < NUM_MOD; m++) begin
				owner[m] <= IDX_W'(NUM_REQ);
			end
			active <= '0;
			grant_o <= '0;
			rvalid <= '0;
			done <= '0;
			for (int r = 0; r < NUM_REQ; r++) begin
				rdata[r] <= '0;
			end
		end else begin
			for (int m = 0; m < NUM_MOD; m++) begin
				owner[m] <= next_owner[m];
			end
			active <= next_active;
			grant_o <= next_grant;
			rvalid <= next_rvalid;
			done <= next_done;
			for (int r = 0; r < NUM_REQ; r++) begin
				rdata[r] <= next_rdata[r];
			end
		end
	end

	// Requester must hold inputs until done
	assign rvalid_o = rvalid;
	assign done_o = done;
	assign rdata_o = rdata;
endmodule

// *** mwx_map.svh ***
`ifndef MWX_MAP_SVH
`define MWX_MAP_SVH
// Requester and module counts
`define MWX_NUM_PROC 2
`define MWX_NUM_IOCU 4
`define MWX_NUM_REQ 6
`define MWX_NUM_MOD 8
// Word layout: 48 data bits plus parity
`define MWX_DATA_W 48
`define MWX_WORD_W 49
`define MWX_PARITY_BIT 48
// Address layout: 3 module bits over 12 word bits
`define MWX_ADDR_W 15
`define MWX_WADDR_W 12
`define MWX_MSEL_W 3
`define MWX_MSEL_LSB 12
`define MWX_MOD_DEPTH 4096
// Timing in nanoseconds and system clock rate
`define MWX_CLK_NS 4
`define MWX_SLOW_CYCLE_NS 6000
`define MWX_FAST_CYCLE_NS 4000
`define MWX_SLOW_READ_NS 3000
`define MWX_FAST_READ_NS 2000
`define MWX_SYS_TICK_NS 1000
`define MWX_CNT_W 11
`endif

// *** mwx_pkg.sv ***
`include "mwx_map.svh"
package mwx_pkg;
	// One word with parity
	typedef logic [`MWX_WORD_W-1:0] mwx_word_type;
	// Word address inside a module
	typedef logic [`MWX_WADDR_W-1:0] mwx_waddr_type;
	// Full requested address
	typedef logic [`MWX_ADDR_W-1:0] mwx_addr_type;
	// Module access cycle states, Gray coded along idle-busy-read-done
	typedef enum logic [1:0] {
		MWX_IDLE = 2'b00,
		MWX_BUSY = 2'b01,
		MWX_READY = 2'b11,
		MWX_DONE = 2'b10
	} mwx_state_type;
endpackage

// *** mwx_port_if.sv ***
`timescale 1ns/1ps
`include "mwx_map.svh"
// Route between the exchange and one memory module
interface mwx_port_if;
	import mwx_pkg::*;
	logic start; // One-cycle start of an access
	logic write; // Direction of the access
	mwx_waddr_type waddr; // Word address for the module
	mwx_word_type wdata; // Write word with parity
	logic busy; // Module in its access cycle
	logic rvalid; // Read word usable (pulse)
	logic done; // Cycle complete (pulse)
	mwx_word_type rdata; // Read word with parity
	modport xbar (output start, write, waddr, wdata, input busy, rvalid, done, rdata);
	modport mem (input start, write, waddr, wdata, output busy, rvalid, done, rdata);
endinterface

// *** mwx_module.sv ***
`timescale 1ns/1ps
`include "mwx_map.svh"
// One independent core memory module
module mwx_module #(
	parameter int DEPTH = `MWX_MOD_DEPTH,
	parameter int CYCLE_CLKS = `MWX_SLOW_CYCLE_NS / `MWX_CLK_NS,
	parameter int READ_CLKS = `MWX_SLOW_READ_NS / `MWX_CLK_NS
) (
	// Clock and reset
	input wire logic clock_i,
	input wire logic reset_i,
	// Route from the exchange
	mwx_port_if.mem port
);
	import mwx_pkg::*;
	mwx_word_type store [DEPTH]; // Core array, parity kept with data
	mwx_state_type state, next_state; // Access cycle state
	mwx_waddr_type addr_reg, next_addr_reg; // Own word-address register
	mwx_word_type buf_reg, next_buf_reg; // Own data buffer register
	logic write_reg, next_write_reg; // Direction latched at start
	logic [`MWX_CNT_W-1:0] cnt, next_cnt; // Cycle clock counter
	logic rvalid, next_rvalid;
	logic done, next_done;

	// Next-state logic for one access cycle
	always_comb begin
		next_state = state;
		next_addr_reg = addr_reg;
		next_buf_reg = buf_reg;
		next_write_reg = write_reg;
		next_cnt = cnt;
		next_rvalid = 1'b0;
		next_done = 1'b0;
		case (state)
			MWX_IDLE: begin
				if (port.start) begin
					next_addr_reg = port.waddr;
					next_buf_reg = port.wdata;
					next_write_reg = port.write;
					next_cnt = '0;
					next_state = MWX_BUSY;
				end
			end
			MWX_BUSY: begin
				next_cnt = cnt + 1'b1;
				if (cnt == `MWX_CNT_W'(READ_CLKS - 2)) begin
					if (!write_reg) begin
						next_buf_reg = store[addr_reg];
					end
					next_rvalid = 1'b1;
					next_state = MWX_READY;
				end
			end
			MWX_READY: begin
				next_cnt = cnt + 1'b1;
				// Remainder of the cycle: module still unavailable
				if (cnt == `MWX_CNT_W'(CYCLE_CLKS - 2)) begin
					next_done = 1'b1;
					next_state = MWX_DONE;
				end
			end
			MWX_DONE: begin
				next_state = MWX_IDLE;
			end
			default: begin
				next_state = MWX_IDLE;
			end
		endcase
	end

	// Register the cycle state
	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			state <= MWX_IDLE;
			addr_reg <= '0;
			buf_reg <= '0;
			write_reg <= 1'b0;
			cnt <= '0;
			rvalid <= 1'b0;
			done <= 1'b0;
		end else begin
			state <= next_state;
			addr_reg <= next_addr_reg;
			buf_reg <= next_buf_reg;
			write_reg <= next_write_reg;
			cnt <= next_cnt;
			rvalid <= next_rvalid;
			done <= next_done;
		end
	end

	// Core write at read time; no reset, it is storage
	always_ff @(posedge clock_i) begin
		if (state == MWX_BUSY && write_reg && next_state == MWX_READY) begin
			store[addr_reg] <= buf_reg;
		end
	end

	assign port.busy = (state != MWX_IDLE);
	assign port.rvalid = rvalid;
	assign port.done = done;
	assign port.rdata = buf_reg;
endmodule

// *** mwx_crossbar_props.sv ***
`timescale 1ns/1ps
`include "mwx_map.svh"
// Timing and ownership checks at the requester ports
module mwx_crossbar_props
	import mwx_pkg::*;
#(
	parameter int NUM_REQ = 6,
	parameter bit FAST_MODULES = 1'b0
) (
	// Clock and reset
	input wire logic clock_i,
	input wire logic reset_i,
	// Requester side
	input wire logic [NUM_REQ-1:0] req_i,
	input wire mwx_pkg::mwx_addr_type addr_i [NUM_REQ],
	// Answers
	input wire logic [NUM_REQ-1:0] grant_o,
	input wire logic [NUM_REQ-1:0] rvalid_o,
	input wire logic [NUM_REQ-1:0] done_o
);
	localparam int CYC = (FAST_MODULES ? `MWX_FAST_CYCLE_NS : `MWX_SLOW_CYCLE_NS) / `MWX_CLK_NS;
	localparam int RD = (FAST_MODULES ? `MWX_FAST_READ_NS : `MWX_SLOW_READ_NS) / `MWX_CLK_NS;
	default clocking @(posedge clock_i); endclocking
	default disable iff (reset_i);
	grant_pulse_a: assert property ((grant_o & $past(grant_o)) == '0)
		else $error("grant longer than one cycle");
	grant_cause_a: assert property ((grant_o & ~$past(req_i)) == '0)
		else $error("grant without request");
	done_grant_a: assert property ((grant_o & done_o) == '0)
		else $error("grant and done together");
	wire [NUM_REQ-1:0] open_v; // Access open per requester
	wire [`MWX_MSEL_W-1:0] tgt [NUM_REQ]; // Module each requester addresses
	for (genvar r = 0; r < NUM_REQ; r++) begin : g_req
		logic [10:0] cnt; // Cycles since grant
		logic [10:0] next_cnt;
		logic act; // Access open
		logic next_act;
		// Count from grant until done
		always_comb begin
			next_act = act;
			next_cnt = cnt;
			if (reset_i) begin
				next_act = 1'b0;
				next_cnt = '0;
			end else if (grant_o[r]) begin
				next_act = 1'b1;
				next_cnt = 11'h001;
			end else if (done_o[r]) begin
				next_act = 1'b0;
			end else if (act) begin
				next_cnt = cnt + 11'h001;
			end
		end
		always_ff @(posedge clock_i) begin
			act <= next_act;
			cnt <= next_cnt;
		end
		assign open_v[r] = act;
		assign tgt[r] = addr_i[r][`MWX_ADDR_W-1:`MWX_MSEL_LSB];
		read_time_a: assert property (rvalid_o[r] |-> act && cnt >= RD && cnt <= RD + 2)
			else $error("read word at wrong time");
		done_time_a: assert property (done_o[r] |-> act && cnt >= CYC && cnt <= CYC + 2)
			else $error("cycle end at wrong time");
		done_bound_a: assert property (act |-> cnt <= CYC + 2)
			else $error("access never completes");
		grant_idle_a: assert property (grant_o[r] |-> !act)
			else $error("grant during open access");
		for (genvar q = r + 1; q < NUM_REQ; q++) begin : g_pair
			one_owner_a: assert property (grant_o[r] && grant_o[q] |-> tgt[r] != tgt[q])
				else $error("two requesters on one module");
		end
		// A module in its cycle must not be handed to a second requester
		for (genvar q = 0; q < NUM_REQ; q++) begin : g_other
			if (q != r) begin : g_ne
				busy_module_a: assert property (open_v[q] && grant_o[r] |-> tgt[r] != tgt[q])
					else $error("module granted while in its cycle");
			end
		end
	end
	all_granted_c: cover property (&grant_o);
	shared_c: cover property ($countones(grant_o) > 1);
	done_c: cover property (done_o[0]);
endmodule
bind mwx_crossbar mwx_crossbar_props #(.NUM_REQ(NUM_REQ), .FAST_MODULES(FAST_MODULES)) u_props (
	.clock_i(clock_i), .reset_i(reset_i), .req_i(req_i), .addr_i(addr_i),
	.grant_o(grant_o), .rvalid_o(rvalid_o), .done_o(done_o));

// *** mwx_req_model.sv ***
`timescale 1ns/1ps
// Requesting unit: holds its request until the exchange completes it
module mwx_req_model
	import mwx_pkg::*;
(
	// Clock and command from the bench
	input wire logic clock_i,
	input wire logic start_i,
	input wire logic write_i,
	input wire mwx_pkg::mwx_addr_type addr_i,
	input wire mwx_pkg::mwx_word_type wdata_i,
	// Answers from the exchange
	input wire logic grant_i,
	input wire logic rvalid_i,
	input wire logic done_i,
	input wire mwx_pkg::mwx_word_type rdata_i,
	// Request toward the exchange
	output logic req_o,
	output logic wr_o,
	output mwx_pkg::mwx_addr_type addr_o,
	output mwx_pkg::mwx_word_type wdata_o,
	// Results for the bench
	output mwx_pkg::mwx_word_type rd_o,
	output logic [31:0] gnt_t_o,
	output logic [31:0] done_t_o
);
	logic [31:0] cyc = '0; // Free cycle count
	initial begin
		{req_o, wr_o, addr_o, wdata_o} = '0;
		{rd_o, gnt_t_o, done_t_o} = '0;
	end
	// Request lines move only just after an edge
	always @(posedge clock_i) begin
		cyc <= cyc + 1;
		if (grant_i) gnt_t_o <= cyc;
		if (rvalid_i && !wr_o) rd_o <= rdata_i;
		if (done_i && req_o) begin
			done_t_o <= cyc;
			#1 req_o = 1'b0;
			// Released lines show garbage, not the old value
			{wr_o, addr_o, wdata_o} = ~{wr_o, addr_o, wdata_o};
		end else if (start_i && !req_o) begin
			#1 {wr_o, addr_o, wdata_o} = {write_i, addr_i, wdata_i};
			req_o = 1'b1;
		end
	end
endmodule

// *** mwx_crossbar_test.sv ***
`timescale 1ns/1ps
`include "mwx_map.svh"
// Six requesters on fast modules, one requester on a slow-module exchange
module mwx_crossbar_test;
	import mwx_pkg::*;
	localparam int CYC = `MWX_FAST_CYCLE_NS / `MWX_CLK_NS;
	localparam int CYC_S = `MWX_SLOW_CYCLE_NS / `MWX_CLK_NS;
	localparam int RD_S = `MWX_SLOW_READ_NS / `MWX_CLK_NS;
	logic clock_i, reset_i;
	logic [5:0] start, cw, grant, rvalid, done;
	wire [5:0] req, wr;
	mwx_addr_type ca [6];
	mwx_word_type cd [6], rdata [6], rd [6];
	wire mwx_addr_type addr [6];
	wire mwx_word_type wd [6];
	logic [31:0] gt [6], dt [6];
	int n_errors, n_tests;
	// Slow exchange, driven straight from the bench
	logic [5:0] s_req, s_wr, s_grant, s_rvalid, s_done;
	mwx_addr_type s_addr [6];
	mwx_word_type s_wd [6], s_rdata [6];
	always #2 clock_i = ~clock_i;
	mwx_crossbar #(.FAST_MODULES(1'b1)) DUT (.clock_i(clock_i), .reset_i(reset_i), .req_i(req),
		.write_i(wr), .addr_i(addr), .wdata_i(wd), .grant_o(grant), .rvalid_o(rvalid),
		.done_o(done), .rdata_o(rdata));
	for (genvar i = 0; i < 6; i++) begin : g_rq
		mwx_req_model u_rq (.clock_i(clock_i), .start_i(start[i]), .write_i(cw[i]),
			.addr_i(ca[i]), .wdata_i(cd[i]), .grant_i(grant[i]), .rvalid_i(rvalid[i]),
			.done_i(done[i]), .rdata_i(rdata[i]), .req_o(req[i]), .wr_o(wr[i]),
			.addr_o(addr[i]), .wdata_o(wd[i]), .rd_o(rd[i]), .gnt_t_o(gt[i]), .done_t_o(dt[i]));
	end
	// Second exchange of the slow module type, so both timings are seen
	mwx_crossbar #(.FAST_MODULES(1'b0)) DUT_SLOW (.clock_i(clock_i), .reset_i(reset_i),
		.req_i(s_req), .write_i(s_wr), .addr_i(s_addr), .wdata_i(s_wd), .grant_o(s_grant),
		.rvalid_o(s_rvalid), .done_o(s_done), .rdata_o(s_rdata));
	// Distinct word per module and address, parity bit varies
	function automatic mwx_word_type pat(int m, int w);
		return {1'(m), 33'h123456789, 3'(m), 12'(w)};
	endfunction
	function automatic int wsel(int r);
		return (r % 2) ? 0 : 'hFFF;
	endfunction
	task automatic check(input bit ok, input string msg);
		n_tests++;
		if (!ok) begin
			n_errors++;
			$display("ERROR at %0t: %s", $time, msg);
		end
	endtask
	task automatic launch(int r, bit w, mwx_addr_type a, mwx_word_type d);
		cw[r] = w;
		ca[r] = a;
		cd[r] = d;
		start[r] = 1'b1;
	endtask
	// Wait, bounded, until every request has been dropped
	task automatic settle();
		int n;
		n = 0;
		@(posedge clock_i);
		#1 start = '0;
		repeat (2) @(posedge clock_i);
		while (req !== '0 && n < 5000) begin
			@(posedge clock_i);
			n++;
		end
		check(n < 5000, "access hung");
		#1;
	endtask
	// All six at once on distinct modules, then cross read-back
	task automatic t_parallel();
		for (int r = 0; r < 6; r++) launch(r, 1'b1, {3'(r + 2), 12'(wsel(r))}, pat(r + 2, wsel(r)));
		settle();
		for (int r = 0; r < 6; r++) begin
			check(gt[r] === gt[0], "grants not together");
			check(dt[r] - gt[r] >= CYC && dt[r] - gt[r] <= CYC + 2, "cycle length");
		end
		for (int r = 0; r < 6; r++) launch(r, 1'b0, {3'(7 - r), 12'(wsel(5 - r))}, '0);
		settle();
		for (int r = 0; r < 6; r++) check(rd[r] === pat(7 - r, wsel(5 - r)), "read word");
		$display("test parallel done");
	endtask
	// Three requesters on one module, one more elsewhere
	task automatic t_priority();
		launch(0, 1'b1, {3'h0, 12'h005}, pat(0, 5));
		settle();
		for (int r = 5; r > 0; r -= 2) launch(r, 1'b0, {3'h0, 12'h005}, '0);
		launch(2, 1'b0, {3'h1, 12'h000}, '0);
		settle();
		check(gt[1] < gt[3] && gt[3] < gt[5], "priority order");
		check(gt[3] > dt[1] && gt[5] > dt[3], "module taken while busy");
		check(gt[2] === gt[1], "other module held back");
		for (int r = 1; r < 6; r += 2) check(rd[r] === pat(0, 5), "shared read");
		$display("test priority done");
	endtask
	// Slow module type: write then read one word, timed from the grant
	task automatic t_slow();
		int t;
		for (int k = 0; k < 2; k++) begin
			s_wr[0] = (k == 0);
			s_addr[0] = {3'h3, 12'h0AA};
			s_wd[0] = pat(3, 'hAA);
			s_req[0] = 1'b1;
			t = 0;
			while (s_grant[0] !== 1'b1 && t < 4) begin
				@(posedge clock_i);
				#1 t = t + 1;
			end
			check(t == 1, "slow grant latency");
			t = 0;
			while (s_done[0] !== 1'b1 && t < 2 * CYC_S) begin
				@(posedge clock_i);
				#1 t = t + 1;
				if (s_rvalid[0] === 1'b1)
					check(t == RD_S && (k == 0 || s_rdata[0] === pat(3, 'hAA)), "slow read");
			end
			check(t == CYC_S, "slow cycle time");
			s_req[0] = 1'b0;
			@(posedge clock_i);
			#1;
		end
		$display("test slow done");
	endtask
	task automatic test_done();
		$display("tests %0d errors %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	initial begin
		#(4 * 20000);
		n_errors++;
		$display("ERROR at %0t: watchdog expired", $time);
		test_done();
	end
	initial begin
		{clock_i, start, cw, s_req, s_wr} = '0;
		reset_i = 1'b1;
		foreach (ca[i]) {ca[i], cd[i], s_addr[i], s_wd[i]} = '0;
		n_errors = 0;
		n_tests = 0;
		repeat (5) @(posedge clock_i);
		#1 reset_i = 1'b0;
		t_parallel();
		t_priority();
		t_slow();
		test_done();
	end
endmodule
